// ### fps_pkg.sv
// Purpose: constants and types for the fault protection supervisor
// Assumes: 20 MHz controller clock, byte-wide register access from the serial engine
// Notes: all offsets are byte addresses of the serial register map
package fps_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS = 8'h21; // status byte
  localparam logic [7:0] ADDR_MASK = 8'h22; // fault_mask
  localparam logic [7:0] ADDR_FAULT = 8'h23; // recorded faults
  localparam logic [7:0] ADDR_PHASE_LIMIT_THRESHOLD_SMP = 8'h2d; // current_limit_sampled
  localparam logic [7:0] ADDR_PHASE_LIMIT_THRESHOLD_INT = 8'h2e; // current_limit_internal
  localparam logic [7:0] ADDR_DROOP = 8'h39; // droop_coefficient_cfg
  localparam logic [7:0] ADDR_SFA = 8'h46; // second_function_latch_a
  localparam logic [7:0] ADDR_SFB = 8'h47; // second_function_latch_b
  localparam logic [7:0] ADDR_TEMP_RSP = 8'h4a; // stage temperature response
  localparam logic [7:0] ADDR_TSD_RSP = 8'h4b; // thermal shutdown response
  localparam logic [7:0] ADDR_BYPASS = 8'h4e; // limit bypass threshold and enable
  localparam logic [7:0] ADDR_OVP_CFG = 8'h4f; // overvoltage configuration
  localparam logic [7:0] ADDR_CLEAR = 8'h52; // write ones to clear status/fault
  localparam logic [7:0] ADDR_HICCUP = 8'h54; // hiccup off time, milliseconds
  // ----------------------------------------------------------------
  // reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_DROOP = 8'h03; // code 3 is load line off
  localparam logic [7:0] RST_HICCUP = 8'h0a; // 10 ms off time
  localparam logic [7:0] PHASE_LIMIT_THRESHOLD_INT_MASK = 8'h1f; // five bit field
  localparam logic [7:0] BYPASS_THR_MASK = 8'h1f; // 35 mV steps from 0.2 V
  localparam int BIT_ST_TEMP = 7;
  localparam int BIT_ST_TSD = 6;
  localparam int BIT_ST_OVP = 5;
  localparam int BIT_M_LINE = 6;
  localparam int BIT_M_TEMP = 5;
  localparam int BIT_M_TSD = 4;
  localparam int BIT_M_TOTAL_CURRENT_LIMIT = 3;
  localparam int BIT_F_OVP = 2;
  localparam int BIT_F_UVP = 1;
  localparam int BIT_SFA_PHASE_LIMIT_THRESHOLD_SEL = 0; // 1 selects internal threshold
  localparam int BIT_RSP_HICCUP = 0; // 1 selects hiccup, 0 latch-off
  localparam int BIT_OVP_DISABLE = 0; // 1 leaves only the 2 V clamp
  localparam int BIT_BYPASS_EN = 7;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 20000000;
  localparam int BYPASS_TIME_MS = 2;
  localparam int HICCUP_UNIT_MS = 1;
  localparam int BYPASS_CYCLES = BYPASS_TIME_MS * (CLK_HZ / 1000);
  localparam int HICCUP_UNIT_CYCLES = HICCUP_UNIT_MS * (CLK_HZ / 1000);
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {FPS_DROOP_100, FPS_DROOP_50, FPS_DROOP_25, FPS_DROOP_0} fps_droop_t;
  typedef enum logic [1:0] {FPS_PWM_OFF, FPS_PWM_LOW, FPS_PWM_MID, FPS_PWM_RUN} fps_pwm_t;
  // comparator results from the analog front end, all asynchronous
  typedef struct packed {
    logic line_restart_ok; // line input above 2.8 V
    logic line_low; // line input below 2.5 V
    logic junction_hot; // junction above 150 C
    logic out_over_2v; // output above fixed 2 V clamp
    logic out_over_ovp; // output 500 mV above reference_input
    logic sum_amp_low; // sum_amp_output below 225 mV
    logic out_below_bypass; // output at or below limit_bypass_threshold
    logic out_below_uv; // output 400 mV below reference_input
    logic phase_limiting; // a phase is being current limited
    logic stage_temp_hi; // stage_temperature_input above 2.0 V
    logic supply_ok; // supply above lockout threshold
    logic enable; // enable pin
  } fps_sense_t;
endpackage

// ### fps_supervisor.sv
// Purpose: digital fault supervisor of a multiphase buck controller
// Assumes: comparator results arrive asynchronously; register port driven by the serial engine
// Notes: registers answer one cycle after a read strobe
`timescale 1ns/10ps
`default_nettype none
module fps_supervisor #(
  parameter int BYPASS_CYC = fps_pkg::BYPASS_CYCLES,
  parameter int HICCUP_UNIT_CYC = fps_pkg::HICCUP_UNIT_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // analog front end comparators and power-on limit sample
  input wire fps_pkg::fps_sense_t sense,
  input wire logic [7:0] phase_limit_threshold_sample_code,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // power stage control
  output fps_pkg::fps_pwm_t pwm_mode,
  output logic driver_enable_out,
  output logic power_good_out,
  output logic soft_start_req,
  output logic per_phase_overcurrent_limit,
  output fps_pkg::fps_droop_t droop_coefficient,
  output logic [7:0] phase_limit_threshold,
  output logic [4:0] limit_bypass_threshold
);
  // ----------------------------------------------------------------
  // input synchronizers
  // ----------------------------------------------------------------
  fps_pkg::fps_sense_t meta_reg; // first stage, read only by s
  fps_pkg::fps_sense_t s; // second stage, safe to use
  logic [7:0] phase_limit_threshold_meta_reg; // first stage of the external limit code
  logic [7:0] phase_limit_threshold_sync_reg; // second stage; the word must be stable as supply rises
  // two flops per comparator, no logic on the first
  always_ff @(posedge clock) begin
    if (rst) begin
      meta_reg <= '0;
      s <= '0;
      phase_limit_threshold_meta_reg <= 8'h00;
      phase_limit_threshold_sync_reg <= 8'h00;
    end else begin
      meta_reg <= sense;
      s <= meta_reg;
      phase_limit_threshold_meta_reg <= phase_limit_threshold_sample_code;
      phase_limit_threshold_sync_reg <= phase_limit_threshold_meta_reg;
    end
  end
  // ----------------------------------------------------------------
  // state and registers
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {ST_LOCK, ST_WAIT_EN, ST_RUN, ST_LATCH, ST_HICCUP} fps_state_t;
  fps_state_t state_reg, state_next;
  fps_pkg::fps_pwm_t latch_pwm_reg, latch_pwm_next; // output form while latched
  logic en_low_reg, en_low_next; // enable seen low since latch
  logic need_line_reg, need_line_next; // line fault needs line ok to restart
  logic [23:0] hic_cnt_reg, hic_cnt_next; // hiccup off time countdown
  logic [16:0] byp_cnt_reg, byp_cnt_next; // limit bypass countdown
  logic ss_reg, ss_next; // soft start pulse
  logic [7:0] status_reg, status_next;
  logic [7:0] fault_reg, fault_next;
  logic [7:0] mask_reg, mask_next;
  logic [7:0] phase_limit_threshold_smp_reg, phase_limit_threshold_smp_next;
  logic [7:0] phase_limit_threshold_int_reg, phase_limit_threshold_int_next;
  logic [7:0] droop_reg, droop_next;
  logic [7:0] sfa_reg, sfa_next;
  logic [7:0] sfb_reg, sfb_next;
  logic [7:0] temp_rsp_reg, temp_rsp_next;
  logic [7:0] tsd_rsp_reg, tsd_rsp_next;
  logic [7:0] bypass_reg, bypass_next;
  logic [7:0] ovp_cfg_reg, ovp_cfg_next;
  logic [7:0] hic_reg, hic_next;
  logic [7:0] rdata_next;
  logic [7:0] thr_next;
  // fault qualifiers
  logic ovp_trip, ocp_trip, uvp_trip, line_trip, temp_trip, tsd_trip;
  logic hiccup_trip;
  logic bypass_active;
  assign bypass_active = (byp_cnt_reg != 17'h00000);
  // overvoltage uses the reference window unless disabled, then the clamp
  assign ovp_trip = ovp_cfg_reg[fps_pkg::BIT_OVP_DISABLE] ? s.out_over_2v : s.out_over_ovp;
  assign ocp_trip = s.sum_amp_low && !mask_reg[fps_pkg::BIT_M_TOTAL_CURRENT_LIMIT];
  assign uvp_trip = s.out_below_uv;
  assign line_trip = s.line_low && !mask_reg[fps_pkg::BIT_M_LINE];
  assign temp_trip = s.stage_temp_hi && !mask_reg[fps_pkg::BIT_M_TEMP];
  assign tsd_trip = s.junction_hot && !mask_reg[fps_pkg::BIT_M_TSD];
  // hiccup only when every active thermal source asks for it
  assign hiccup_trip = (temp_trip || tsd_trip)
    && (!temp_trip || temp_rsp_reg[fps_pkg::BIT_RSP_HICCUP])
    && (!tsd_trip || tsd_rsp_reg[fps_pkg::BIT_RSP_HICCUP]);
  // ----------------------------------------------------------------
  // protection state machine
  // ----------------------------------------------------------------
  // latched faults take priority over hiccup; overvoltage wins the pwm form
  always_comb begin
    state_next = state_reg;
    latch_pwm_next = latch_pwm_reg;
    en_low_next = en_low_reg || !s.enable;
    need_line_next = need_line_reg;
    hic_cnt_next = hic_cnt_reg;
    byp_cnt_next = byp_cnt_reg;
    ss_next = 1'b0;
    case (state_reg)
      ST_LOCK: begin
        // nothing runs until the supply is good
        if (s.supply_ok) begin
          state_next = ST_WAIT_EN;
        end
      end
      ST_WAIT_EN: begin
        if (s.enable) begin
          state_next = ST_RUN;
          ss_next = 1'b1;
        end
      end
      ST_RUN: begin
        // bypass window opens while limiting drags output to threshold
        if (bypass_active) begin
          byp_cnt_next = byp_cnt_reg - 17'h00001;
        end else if (bypass_reg[fps_pkg::BIT_BYPASS_EN] && s.phase_limiting && s.out_below_bypass) begin
          byp_cnt_next = 17'(BYPASS_CYC);
        end
        if (!s.enable) begin
          state_next = ST_WAIT_EN;
        end else if (ovp_trip || ocp_trip || uvp_trip || line_trip || ((temp_trip || tsd_trip) && !hiccup_trip)) begin
          state_next = ST_LATCH;
          en_low_next = 1'b0;
          need_line_next = line_trip;
          // mid-state only for total overcurrent without overvoltage
          latch_pwm_next = (ocp_trip && !ovp_trip) ? fps_pkg::FPS_PWM_MID : fps_pkg::FPS_PWM_LOW;
          byp_cnt_next = 17'h00000;
        end else if (hiccup_trip) begin
          state_next = ST_HICCUP;
          hic_cnt_next = 24'(int'(hic_reg) * HICCUP_UNIT_CYC) + 24'h000001;
          byp_cnt_next = 17'h00000;
        end
      end
      ST_LATCH: begin
        // release only after enable goes low then high again
        if (en_low_reg && s.enable && (!need_line_reg || s.line_restart_ok)) begin
          state_next = ST_RUN;
          ss_next = 1'b1;
        end
      end
      ST_HICCUP: begin
        if (!s.enable) begin
          state_next = ST_WAIT_EN;
        end else if (hic_cnt_reg <= 24'h000001) begin
          state_next = ST_RUN;
          ss_next = 1'b1;
        end else begin
          hic_cnt_next = hic_cnt_reg - 24'h000001;
        end
      end
      default: begin
        state_next = ST_LOCK;
      end
    endcase
    // losing the supply resets the sequence from anywhere
    if (!s.supply_ok) begin
      state_next = ST_LOCK;
      byp_cnt_next = 17'h00000;
    end
  end
  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  // hardware sets win over software clears in the same cycle
  always_comb begin
    status_next = status_reg;
    fault_next = fault_reg;
    mask_next = mask_reg;
    phase_limit_threshold_smp_next = phase_limit_threshold_smp_reg;
    phase_limit_threshold_int_next = phase_limit_threshold_int_reg;
    droop_next = droop_reg;
    sfa_next = sfa_reg;
    sfb_next = sfb_reg;
    temp_rsp_next = temp_rsp_reg;
    tsd_rsp_next = tsd_rsp_reg;
    bypass_next = bypass_reg;
    ovp_cfg_next = ovp_cfg_reg;
    hic_next = hic_reg;
    rdata_next = reg_rdata;
    // power-on capture of the externally set limit
    if (state_reg == ST_LOCK && s.supply_ok) begin
      phase_limit_threshold_smp_next = phase_limit_threshold_sync_reg;
    end
    if (reg_wr) begin
      case (reg_addr)
        fps_pkg::ADDR_MASK: mask_next = reg_wdata;
        fps_pkg::ADDR_PHASE_LIMIT_THRESHOLD_INT: phase_limit_threshold_int_next = reg_wdata & fps_pkg::PHASE_LIMIT_THRESHOLD_INT_MASK;
        fps_pkg::ADDR_DROOP: droop_next = {6'h00, reg_wdata[1:0]};
        fps_pkg::ADDR_SFA: sfa_next = reg_wdata;
        fps_pkg::ADDR_SFB: sfb_next = reg_wdata;
        fps_pkg::ADDR_TEMP_RSP: temp_rsp_next = reg_wdata;
        fps_pkg::ADDR_TSD_RSP: tsd_rsp_next = reg_wdata;
        fps_pkg::ADDR_BYPASS: bypass_next = reg_wdata & (fps_pkg::BYPASS_THR_MASK | 8'h80);
        fps_pkg::ADDR_OVP_CFG: ovp_cfg_next = reg_wdata;
        fps_pkg::ADDR_HICCUP: hic_next = reg_wdata;
        fps_pkg::ADDR_CLEAR: begin
          status_next = status_reg & ~reg_wdata;
          fault_next = fault_reg & ~reg_wdata;
        end
        default: begin
          // read-only or unmapped, write ignored
        end
      endcase
    end
    // status and fault record, regardless of mask
    if (s.stage_temp_hi) begin
      status_next[fps_pkg::BIT_ST_TEMP] = 1'b1;
      fault_next[fps_pkg::BIT_M_TEMP] = 1'b1;
    end
    if (s.junction_hot) begin
      status_next[fps_pkg::BIT_ST_TSD] = 1'b1;
      fault_next[fps_pkg::BIT_M_TSD] = 1'b1;
    end
    if (state_reg == ST_RUN && s.enable && ovp_trip) begin
      status_next[fps_pkg::BIT_ST_OVP] = 1'b1;
      fault_next[fps_pkg::BIT_F_OVP] = 1'b1;
    end
    if (s.sum_amp_low) begin
      fault_next[fps_pkg::BIT_M_TOTAL_CURRENT_LIMIT] = 1'b1;
    end
    if (s.line_low) begin
      fault_next[fps_pkg::BIT_M_LINE] = 1'b1;
    end
    if (state_reg == ST_RUN && uvp_trip) begin
      fault_next[fps_pkg::BIT_F_UVP] = 1'b1;
    end
    if (reg_rd) begin
      case (reg_addr)
        fps_pkg::ADDR_STATUS: rdata_next = status_reg & 8'he0;
        fps_pkg::ADDR_MASK: rdata_next = mask_reg;
        fps_pkg::ADDR_FAULT: rdata_next = fault_reg;
        fps_pkg::ADDR_PHASE_LIMIT_THRESHOLD_SMP: rdata_next = phase_limit_threshold_smp_reg;
        fps_pkg::ADDR_PHASE_LIMIT_THRESHOLD_INT: rdata_next = phase_limit_threshold_int_reg;
        fps_pkg::ADDR_DROOP: rdata_next = droop_reg;
        fps_pkg::ADDR_SFA: rdata_next = sfa_reg;
        fps_pkg::ADDR_SFB: rdata_next = sfb_reg;
        fps_pkg::ADDR_TEMP_RSP: rdata_next = temp_rsp_reg;
        fps_pkg::ADDR_TSD_RSP: rdata_next = tsd_rsp_reg;
        fps_pkg::ADDR_BYPASS: rdata_next = bypass_reg;
        fps_pkg::ADDR_OVP_CFG: rdata_next = ovp_cfg_reg;
        fps_pkg::ADDR_HICCUP: rdata_next = hic_reg;
        default: rdata_next = 8'h00;
      endcase
    end
    // limit source select, external by default
    thr_next = sfa_reg[fps_pkg::BIT_SFA_PHASE_LIMIT_THRESHOLD_SEL] ? phase_limit_threshold_int_reg : phase_limit_threshold_smp_reg;
  end
  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= ST_LOCK;
      latch_pwm_reg <= fps_pkg::FPS_PWM_LOW;
      en_low_reg <= 1'b0;
      need_line_reg <= 1'b0;
      hic_cnt_reg <= 24'h000000;
      byp_cnt_reg <= 17'h00000;
      ss_reg <= 1'b0;
      status_reg <= fps_pkg::RST_ZERO;
      fault_reg <= fps_pkg::RST_ZERO;
      mask_reg <= fps_pkg::RST_ZERO;
      phase_limit_threshold_smp_reg <= fps_pkg::RST_ZERO;
      phase_limit_threshold_int_reg <= fps_pkg::RST_ZERO;
      droop_reg <= fps_pkg::RST_DROOP;
      sfa_reg <= fps_pkg::RST_ZERO;
      sfb_reg <= fps_pkg::RST_ZERO;
      temp_rsp_reg <= fps_pkg::RST_ZERO;
      tsd_rsp_reg <= fps_pkg::RST_ZERO;
      bypass_reg <= fps_pkg::RST_ZERO;
      ovp_cfg_reg <= fps_pkg::RST_ZERO;
      hic_reg <= fps_pkg::RST_HICCUP;
      reg_rdata <= 8'h00;
      phase_limit_threshold <= 8'h00;
    end else begin
      state_reg <= state_next;
      latch_pwm_reg <= latch_pwm_next;
      en_low_reg <= en_low_next;
      need_line_reg <= need_line_next;
      hic_cnt_reg <= hic_cnt_next;
      byp_cnt_reg <= byp_cnt_next;
      ss_reg <= ss_next;
      status_reg <= status_next;
      fault_reg <= fault_next;
      mask_reg <= mask_next;
      phase_limit_threshold_smp_reg <= phase_limit_threshold_smp_next;
      phase_limit_threshold_int_reg <= phase_limit_threshold_int_next;
      droop_reg <= droop_next;
      sfa_reg <= sfa_next;
      sfb_reg <= sfb_next;
      temp_rsp_reg <= temp_rsp_next;
      tsd_rsp_reg <= tsd_rsp_next;
      bypass_reg <= bypass_next;
      ovp_cfg_reg <= ovp_cfg_next;
      hic_reg <= hic_next;
      reg_rdata <= rdata_next;
      phase_limit_threshold <= thr_next;
    end
  end
  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign pwm_mode = (state_reg == ST_RUN) ? fps_pkg::FPS_PWM_RUN :
                    (state_reg == ST_LATCH) ? latch_pwm_reg : fps_pkg::FPS_PWM_OFF;
  assign driver_enable_out = (state_reg == ST_RUN);
  assign power_good_out = (state_reg == ST_RUN) && !ss_reg;
  assign soft_start_req = ss_reg;
  assign per_phase_overcurrent_limit = !bypass_active;
  assign droop_coefficient = fps_pkg::fps_droop_t'(droop_reg[1:0]);
  assign limit_bypass_threshold = bypass_reg[4:0];
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_ovp_shutdown: assert property (state_reg == ST_RUN && s.supply_ok && s.enable && ovp_trip
    |=> pwm_mode == fps_pkg::FPS_PWM_LOW && !driver_enable_out && !power_good_out) else $error("ovp no shutdown");
  a_ocp_midstate: assert property (state_reg == ST_RUN && s.supply_ok && s.enable && ocp_trip && !ovp_trip
    |=> pwm_mode == fps_pkg::FPS_PWM_MID) else $error("ocp not mid");
  a_latch_needs_toggle: assert property (state_reg == ST_LATCH && !en_low_reg && s.supply_ok
    |=> state_reg != ST_RUN) else $error("released without toggle");
  a_lockout_hold: assert property (!s.supply_ok |=> state_reg == ST_LOCK ##1 !driver_enable_out)
    else $error("active without supply");
  a_bypass_window: assert property ($rose(bypass_active) |-> !per_phase_overcurrent_limit [*8])
    else $error("bypass too short");
  a_status_temp: assert property (s.stage_temp_hi |=> status_reg[fps_pkg::BIT_ST_TEMP] && fault_reg[fps_pkg::BIT_M_TEMP])
    else $error("temp not recorded");
  a_phase_limit_threshold_select: assert property (##1 phase_limit_threshold ==
    ($past(sfa_reg[fps_pkg::BIT_SFA_PHASE_LIMIT_THRESHOLD_SEL]) ? $past(phase_limit_threshold_int_reg) : $past(phase_limit_threshold_smp_reg)))
    else $error("wrong limit source");
  a_hiccup_retry: assert property (state_reg == ST_HICCUP && hic_cnt_reg == 24'h000001 && s.enable && s.supply_ok
    |=> state_reg == ST_RUN && soft_start_req) else $error("hiccup no retry");
  a_line_restart: assert property (state_reg == ST_LATCH && need_line_reg && !s.line_restart_ok
    |=> state_reg != ST_RUN) else $error("line restart early");
  a_masked_temp: assert property (state_reg == ST_RUN && s.enable && s.supply_ok && mask_reg[fps_pkg::BIT_M_TEMP]
    && !ovp_trip && !ocp_trip && !uvp_trip && !line_trip && !tsd_trip |=> state_reg == ST_RUN)
    else $error("masked temp acted");
  c_ocp_latch: cover property (state_reg == ST_RUN ##1 pwm_mode == fps_pkg::FPS_PWM_MID);
  c_hiccup: cover property (state_reg == ST_HICCUP ##[1:100] state_reg == ST_RUN);
  c_toggle_release: cover property (state_reg == ST_LATCH ##1 state_reg == ST_RUN);
endmodule
`default_nettype wire

// ### fps_front_end.sv
// Purpose: behavioural stand-in for the power stages and analog comparators
// Assumes: levels in millivolts, junction in degrees C
// Notes: ideal comparators, no hysteresis or noise
`timescale 1ns/10ps
`default_nettype none
module fps_front_end (
  // analog levels set by the bench
  input var int vout_mv,
  input var int reference_input_mv,
  input var int csum_mv,
  input var int stage_temperature_input_mv,
  input var int tj_c,
  input var int line_input_monitor_mv,
  // digital levels, bypass code fed back from the supervisor
  input wire logic vcc_ok,
  input wire logic en,
  input wire logic limiting,
  input wire logic [4:0] bypass_code,
  // comparator bundle, changes at any time like the real pins
  output var fps_pkg::fps_sense_t sense
);
  // every threshold becomes a plain level; the supervisor must synchronize it
  always_comb begin
    sense.line_restart_ok = line_input_monitor_mv > 2800;
    sense.line_low = line_input_monitor_mv < 2500;
    sense.junction_hot = tj_c > 150;
    sense.out_over_2v = vout_mv > 2000;
    sense.out_over_ovp = vout_mv > reference_input_mv + 500;
    sense.sum_amp_low = csum_mv < 225;
    sense.out_below_bypass = vout_mv <= 200 + 35 * int'(bypass_code);
    sense.out_below_uv = vout_mv < reference_input_mv - 400;
    sense.phase_limiting = limiting;
    sense.stage_temp_hi = stage_temperature_input_mv > 2000;
    sense.supply_ok = vcc_ok;
    sense.enable = en;
  end
endmodule
`default_nettype wire

// ### fps_supervisor_test.sv
// Purpose: self-checking bench for the fault protection supervisor
// Assumes: inputs move on the falling edge; reads answer one cycle later
// Notes: short bypass and hiccup counts keep the run brief
`timescale 1ns/10ps
`default_nettype none
module fps_supervisor_test;
  // ------------------------------------------------------------
  // bench state and wiring
  // ------------------------------------------------------------
  localparam fps_pkg::fps_pwm_t OFF = fps_pkg::FPS_PWM_OFF;
  localparam fps_pkg::fps_pwm_t LOW = fps_pkg::FPS_PWM_LOW;
  localparam fps_pkg::fps_pwm_t MID = fps_pkg::FPS_PWM_MID;
  localparam fps_pkg::fps_pwm_t RUN = fps_pkg::FPS_PWM_RUN;
  logic clock = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, vcc_ok = 1'b0, en = 1'b0, limiting = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, phase_limit_threshold_code = 8'h9c, reg_rdata, plt;
  logic drv, pg, ss, lim;
  logic [4:0] lbt;
  fps_pkg::fps_sense_t sense;
  fps_pkg::fps_pwm_t pwm_mode;
  fps_pkg::fps_droop_t droop;
  int vout_mv = 1000, reference_input_mv = 1000, csum_mv = 800, stage_temperature_input_mv = 1000, tj_c = 50, line_input_monitor_mv = 5000;
  int error_cnt = 0, samples_checked = 0, cycles = 0, ss_cnt = 0;
  initial begin
    forever #25 clock = ~clock;
  end
  fps_front_end fps_front_end_i (.vout_mv(vout_mv), .reference_input_mv(reference_input_mv), .csum_mv(csum_mv), .stage_temperature_input_mv(stage_temperature_input_mv),
    .tj_c(tj_c), .line_input_monitor_mv(line_input_monitor_mv), .vcc_ok(vcc_ok), .en(en), .limiting(limiting), .bypass_code(lbt), .sense(sense));
  fps_supervisor #(.BYPASS_CYC(20), .HICCUP_UNIT_CYC(5)) fps_supervisor_i (.clock(clock), .rst(rst), .sense(sense),
    .phase_limit_threshold_sample_code(phase_limit_threshold_code), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .pwm_mode(pwm_mode), .driver_enable_out(drv), .power_good_out(pg), .soft_start_req(ss),
    .per_phase_overcurrent_limit(lim), .droop_coefficient(droop), .phase_limit_threshold(plt),
    .limit_bypass_threshold(lbt));
  // ------------------------------------------------------------
  // access and compare tasks
  // ------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // strobe low for a cycle after each access so back-to-back calls never double-drive
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_rd = 1'b1;
    tick(1);
    reg_rd = 1'b0;
    chk("rdata", e, reg_rdata);
    tick(1);
  endtask
  task automatic st(input fps_pkg::fps_pwm_t p);
    chk("pwm_mode", {6'h00, p}, {6'h00, pwm_mode});
    chk("driver_enable_out", {7'h00, p == RUN}, {7'h00, drv});
    chk("power_good_out", {7'h00, p == RUN}, {7'h00, pg});
  endtask
  task automatic restart();
    en = 1'b0;
    tick(5);
    en = 1'b1;
    tick(6);
  endtask
  task automatic calm();
    vout_mv = 1000;
    reference_input_mv = 1000;
    csum_mv = 800;
    stage_temperature_input_mv = 1000;
    tj_c = 50;
    line_input_monitor_mv = 5000;
  endtask
  // force one fault, check the response and record, then clear and restart
  task automatic trip(input int k, input fps_pkg::fps_pwm_t p, input logic [7:0] ra, input logic [7:0] rv);
    case (k)
      0: stage_temperature_input_mv = 2100;
      1: tj_c = 160;
      2: csum_mv = 200;
      3: vout_mv = 1600;
      4: vout_mv = 500;
      5: line_input_monitor_mv = 2400;
      default: vout_mv = 2100;
    endcase
    tick(5);
    st(p);
    rd(ra, rv);
    calm();
    tick(5);
    wr(8'h52, 8'hff);
    restart();
    st(RUN);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // cycle ceiling and retry counter
  always @(posedge clock) begin
    cycles++;
    if (ss === 1'b1)
      ss_cnt++;
    if (cycles == 5000) begin
      error_cnt++;
      wrap_up();
    end
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    tick(4);
    rst = 1'b0;
    st(OFF);
    rd(8'h39, 8'h03);
    rd(8'h60, 8'h00);
    rd(8'h22, 8'h00);
    rd(8'h46, 8'h00);
    wr(8'h47, 8'h5a);
    rd(8'h47, 8'h5a);
    for (int i = 3; i >= 0; i--) begin
      wr(8'h39, 8'(i));
      chk("droop", 8'(i), {6'h00, droop});
    end
    wr(8'h2e, 8'hff);
    rd(8'h2e, 8'h1f);
    en = 1'b1;
    tick(6);
    st(OFF);
    vcc_ok = 1'b1;
    restart();
    st(RUN);
    phase_limit_threshold_code = 8'h33;
    rd(8'h2d, 8'h9c);
    chk("phase_limit_threshold", 8'h9c, plt);
    wr(8'h46, 8'h01);
    chk("phase_limit_threshold", 8'h1f, plt);
    wr(8'h4e, 8'h85);
    rd(8'h4e, 8'h85);
    chk("limit_bypass_threshold", 8'h05, {3'h0, lbt});
    chk("overcurrent_limit", 8'h01, {7'h00, lim});
    reference_input_mv = 500;
    vout_mv = 370;
    limiting = 1'b1;
    tick(5);
    chk("overcurrent_limit", 8'h00, {7'h00, lim});
    calm();
    limiting = 1'b0;
    tick(25);
    chk("overcurrent_limit", 8'h01, {7'h00, lim});
    trip(0, LOW, 8'h21, 8'h80);
    trip(1, LOW, 8'h21, 8'h40);
    trip(2, MID, 8'h23, 8'h08);
    trip(3, LOW, 8'h21, 8'h20);
    trip(4, LOW, 8'h23, 8'h02);
    trip(5, LOW, 8'h23, 8'h40);
    wr(8'h4f, 8'h01);
    vout_mv = 1600;
    tick(5);
    st(RUN);
    trip(6, LOW, 8'h21, 8'h20);
    line_input_monitor_mv = 2400;
    tick(5);
    line_input_monitor_mv = 2600;
    restart();
    chk("driver_enable_out", 8'h00, {7'h00, drv});
    line_input_monitor_mv = 5000;
    restart();
    st(RUN);
    wr(8'h52, 8'hff);
    wr(8'h22, 8'h20);
    stage_temperature_input_mv = 2100;
    tick(5);
    st(RUN);
    rd(8'h23, 8'h20);
    stage_temperature_input_mv = 1000;
    tick(5);
    wr(8'h52, 8'hff);
    wr(8'h22, 8'h58);
    tj_c = 160;
    csum_mv = 200;
    line_input_monitor_mv = 2400;
    tick(5);
    st(RUN);
    rd(8'h23, 8'h58);
    calm();
    tick(5);
    wr(8'h52, 8'hff);
    wr(8'h22, 8'h00);
    wr(8'h4a, 8'h01);
    wr(8'h54, 8'h01);
    stage_temperature_input_mv = 2100;
    tick(4);
    st(OFF);
    ss_cnt = 0;
    tick(30);
    chk("retry_count", 8'h01, {7'h00, ss_cnt >= 2});
    stage_temperature_input_mv = 1000;
    tick(20);
    st(RUN);
    wr(8'h4b, 8'h01);
    tj_c = 160;
    tick(4);
    st(OFF);
    tj_c = 50;
    tick(20);
    st(RUN);
    vcc_ok = 1'b0;
    tick(4);
    st(OFF);
    vcc_ok = 1'b1;
    restart();
    st(RUN);
    rd(8'h2d, 8'h33);
    wrap_up();
  end
endmodule
`default_nettype wire
